//--- src/thermal_monitor_pkg.sv
// thermal monitor package: register map, field positions, timing counts
// assumes a 200 MHz system clock and a 32-bit apb register bus
package thermal_monitor_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int DEB_TIME_NS = 100; // least stable time before a level counts
  localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CNT_W = 5;
  localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEB_CYCLES - 1);
  localparam logic [DEB_CNT_W-1:0] DEB_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_SLEEP_CFG = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_INT_STS = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_SHDN_STS = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_LIVE = 12'h014;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;     // protection enable
  localparam int CTRL_THR_LSB = 1;    // two-bit warning threshold select
  localparam int SLP_MASK_BIT = 0;    // trip mask, honoured in sleep or test mode only
  localparam int INT_TRIP_BIT = 0;    // thermal trip event
  localparam int INT_WARN_BIT = 5;    // over-temperature warning event
  localparam int INT_W = 6;
  localparam int SHDN_BIT = 0;        // thermal shutdown record
  localparam int LIVE_WARN_BIT = 0;
  localparam int LIVE_TRIP_BIT = 1;
  localparam int LIVE_BLOCK_BIT = 2;
  localparam int LIVE_ACT_BIT = 3;

  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [1:0] THR_RESET = 2'h0; // lowest warning level
  localparam logic [INT_W-1:0] INT_MASK_RESET = 6'h00;
  localparam logic [INT_W-1:0] INT_ZERO = 6'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYN_W = 5;
  localparam int SYN_WARN_A = 0;
  localparam int SYN_WARN_B = 1;
  localparam int SYN_TRIP_A = 2;
  localparam int SYN_TRIP_B = 3;
  localparam int SYN_TEST = 4;
  localparam logic [SYN_W-1:0] SYN_ZERO = 5'h00;

  // power state reported by the sequencer
  typedef enum logic [2:0] {PS_OFF, PS_BACKUP, PS_WAITON, PS_SLEEP, PS_ACTIVE} powerState_t;

endpackage : thermal_monitor_pkg

//--- src/comparator_debouncer.sv
// debouncer for one comparator level
// assumes rawLvl is already synchronised to clock
module comparator_debouncer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic rawLvl,
  output logic stableLvl
);
  import thermal_monitor_pkg::*;

  logic [DEB_CNT_W-1:0] cnt_q;
  logic stable_q;

  // ----------------------------------------------------------------
  // stability counter
  // ----------------------------------------------------------------
  // count while the raw level differs from the accepted one; any return
  // restarts the count, so glitches shorter than the window vanish
  always_ff @(posedge clock) begin
    if (!rst_n || hold) begin
      cnt_q <= DEB_ZERO;
      stable_q <= 1'b0;
    end else if (rawLvl == stable_q) begin
      cnt_q <= DEB_ZERO;
    end else if (cnt_q == DEB_LAST) begin
      cnt_q <= DEB_ZERO;
      stable_q <= rawLvl;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign stableLvl = stable_q;

endmodule : comparator_debouncer

//--- src/die_thermal_monitor.sv
// die thermal monitor: warning interrupt and thermal trip switch-off
// assumes comparator and test pins are asynchronous, power state and
// restart request come from logic on the same clock
//
// Notes on behaviour
// - protection runs out of reset except in backup and off states
// - in sleep, software cannot disable the protection
// - both warning and both trip detectors merge into one monitor each
// - debounced warning crossing raises an interrupt
// - two-bit field selects one of four warning thresholds
// - one warning interrupt per excursion, re-armed after release
// - warning feeds the single interrupt collector output, no own pin
// - trip requests switch-off at once and sets shutdown status
// - restart blocked after trip until warning comparator clears
// - trip comparator is debounced before requesting switch-off
// - trip mask honoured only in sleep or test mode
// - warning status sits at bit 5, set by either detector
//
// The APB register port and the register offsets were left to the implementer.
module die_thermal_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [thermal_monitor_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic warnCmpA,
  input wire logic warnCmpB,
  input wire logic tripCmpA,
  input wire logic tripCmpB,
  input wire logic testMode,
  input wire thermal_monitor_pkg::powerState_t powerState,
  input wire logic restartReq,
  output logic [1:0] thrSel,
  output logic switchOffReq,
  output logic restartGrant,
  output logic irq
);
  import thermal_monitor_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [SYN_W-1:0] syncA_q, syncB_q, syncC_q, clean_q;
  logic protEn_q, tripMask_q, shdnSts_q, restartBlocked_q;
  logic [1:0] thr_q;
  logic [INT_W-1:0] intSts_q, intMask_q, intSet, rdClr_q;
  logic [31:0] prdata_q, rdData;
  logic pready_q, pslverr_q, switchOff_q, grant_q, irq_q;
  logic warnLvl, tripLvl, warnPrev_q, warnRise;
  logic inSleep, powered, protActive, monitorRun, tripMaskEff, tripAct;
  logic apbSetup, apbWr, apbRd, wrLow, mapped;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; a level counts only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA_q <= SYN_ZERO;
      syncB_q <= SYN_ZERO;
      syncC_q <= SYN_ZERO;
      clean_q <= SYN_ZERO;
    end else begin
      syncA_q <= {testMode, tripCmpB, tripCmpA, warnCmpB, warnCmpA};
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      for (int i = 0; i < SYN_W; i++) begin
        if (syncB_q[i] == syncC_q[i]) clean_q[i] <= syncC_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // power state qualification
  // ----------------------------------------------------------------
  assign inSleep = (powerState == PS_SLEEP);
  assign powered = (powerState != PS_BACKUP) && (powerState != PS_OFF);
  // sleep forces protection on whatever the enable bit says
  assign protActive = powered && (protEn_q || inSleep);
  // keep watching after a trip even when off, so cool-down is seen
  assign monitorRun = protActive || restartBlocked_q;
  // the mask bit is ignored outside sleep unless test mode is strapped
  assign tripMaskEff = tripMask_q && (inSleep || clean_q[SYN_TEST]);

  // ----------------------------------------------------------------
  // debounced comparator levels
  // ----------------------------------------------------------------
  // the two sites are ored first: one logical warning, one logical trip
  comparator_debouncer warnDeb (
    .clock(clock),
    .rst_n(rst_n),
    .hold(!monitorRun),
    .rawLvl(clean_q[SYN_WARN_A] | clean_q[SYN_WARN_B]),
    .stableLvl(warnLvl)
  );

  comparator_debouncer tripDeb (
    .clock(clock),
    .rst_n(rst_n),
    .hold(!monitorRun),
    .rawLvl(clean_q[SYN_TRIP_A] | clean_q[SYN_TRIP_B]),
    .stableLvl(tripLvl)
  );

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // the comparator has its own hysteresis; a rising edge of the settled
  // level therefore marks exactly one excursion
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      warnPrev_q <= 1'b0;
    end else begin
      warnPrev_q <= warnLvl;
    end
  end

  assign warnRise = warnLvl && !warnPrev_q && protActive;
  assign tripAct = tripLvl && protActive && !tripMaskEff;

  always_comb begin
    intSet = INT_ZERO;
    intSet[INT_WARN_BIT] = warnRise;
    intSet[INT_TRIP_BIT] = tripAct;
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && pready_q && pwrite;
  assign apbRd = psel && penable && pready_q && !pwrite;
  assign wrLow = apbWr && pstrb[0] && !pslverr_q; // every field sits in byte 0

  always_comb begin
    rdData = WORD_ZERO;
    mapped = 1'b1;
    unique case (paddr)
      ADDR_CTRL: begin
        rdData[CTRL_EN_BIT] = protEn_q;
        rdData[CTRL_THR_LSB +: 2] = thr_q;
      end
      ADDR_SLEEP_CFG: rdData[SLP_MASK_BIT] = tripMask_q;
      ADDR_INT_STS: rdData[INT_W-1:0] = intSts_q;
      ADDR_INT_MASK: rdData[INT_W-1:0] = intMask_q;
      ADDR_SHDN_STS: rdData[SHDN_BIT] = shdnSts_q;
      ADDR_LIVE: begin
        rdData[LIVE_WARN_BIT] = warnLvl;
        rdData[LIVE_TRIP_BIT] = tripLvl;
        rdData[LIVE_BLOCK_BIT] = restartBlocked_q;
        rdData[LIVE_ACT_BIT] = protActive;
      end
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // apb response
  // ----------------------------------------------------------------
  // data and ready are prepared in the setup cycle so every bus output
  // leaves a flip-flop; the access phase always lasts one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= WORD_ZERO;
      rdClr_q <= INT_ZERO;
    end else begin
      pready_q <= apbSetup;
      if (apbSetup) begin
        pslverr_q <= !mapped;
        prdata_q <= pwrite ? WORD_ZERO : rdData;
        rdClr_q <= (!pwrite && paddr == ADDR_INT_STS) ? intSts_q : INT_ZERO;
      end else if (!psel) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      protEn_q <= CTRL_EN_RESET;
      thr_q <= THR_RESET;
      tripMask_q <= 1'b0;
      intMask_q <= INT_MASK_RESET;
    end else if (wrLow) begin
      if (paddr == ADDR_CTRL) begin
        // a clear of the enable during sleep is dropped
        protEn_q <= pwdata[CTRL_EN_BIT] || inSleep;
        thr_q <= pwdata[CTRL_THR_LSB +: 2];
      end
      if (paddr == ADDR_SLEEP_CFG) tripMask_q <= pwdata[SLP_MASK_BIT];
      if (paddr == ADDR_INT_MASK) intMask_q <= pwdata[INT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and collector output
  // ----------------------------------------------------------------
  // read clears only the bits returned; a new event in the same cycle wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      intSts_q <= INT_ZERO;
    end else if (apbRd && !pslverr_q) begin
      intSts_q <= (intSts_q & ~rdClr_q) | intSet;
    end else begin
      intSts_q <= intSts_q | intSet;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(intSts_q & intMask_q);
    end
  end

  // ----------------------------------------------------------------
  // thermal trip: switch-off, shutdown record, restart block
  // ----------------------------------------------------------------
  // shutdown record survives the power cycle; only a written one clears,
  // and a trip in the same cycle keeps it set
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shdnSts_q <= 1'b0;
    end else if (tripAct) begin
      shdnSts_q <= 1'b1;
    end else if (wrLow && paddr == ADDR_SHDN_STS && pwdata[SHDN_BIT]) begin
      shdnSts_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      switchOff_q <= 1'b0;
    end else begin
      switchOff_q <= tripAct;
    end
  end

  // block lifts only once the warning level, below the trip, has cleared
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      restartBlocked_q <= 1'b0;
    end else if (tripAct) begin
      restartBlocked_q <= 1'b1;
    end else if (!warnLvl && !tripLvl) begin
      restartBlocked_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      grant_q <= 1'b0;
    end else begin
      grant_q <= restartReq && !restartBlocked_q && !tripAct;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign thrSel = thr_q; // software keeps it below the trip level
  assign switchOffReq = switchOff_q;
  assign restartGrant = grant_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_inactive_quiet;
    (powerState == PS_OFF || powerState == PS_BACKUP) |=> !switchOffReq;
  endproperty
  a_inactive_quiet: assert property (p_inactive_quiet) else $error("trip outside powered states");
  property p_sleep_keeps_en;
    inSleep && wrLow && paddr == ADDR_CTRL |=> protEn_q;
  endproperty
  a_sleep_keeps_en: assert property (p_sleep_keeps_en) else $error("enable cleared in sleep");
  property p_warn_sets_bit5;
    warnRise |=> intSts_q[INT_WARN_BIT];
  endproperty
  a_warn_sets_bit5: assert property (p_warn_sets_bit5) else $error("warning status missed");
  property p_one_per_excursion;
    warnRise |=> !warnRise throughout (warnLvl [*2]);
  endproperty
  a_one_per_excursion: assert property (p_one_per_excursion) else $error("second warning");
  property p_thr_write;
    wrLow && paddr == ADDR_CTRL |=> thrSel == $past(pwdata[CTRL_THR_LSB +: 2]);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold not stored");
  property p_trip_switchoff;
    tripLvl && protActive && !inSleep && !clean_q[SYN_TEST] |=> switchOffReq && shdnSts_q;
  endproperty
  a_trip_switchoff: assert property (p_trip_switchoff) else $error("trip not acted on");
  property p_blocked_no_grant;
    restartBlocked_q |=> !restartGrant;
  endproperty
  a_blocked_no_grant: assert property (p_blocked_no_grant) else $error("restart while blocked");
  // the raw level must have been high one cycle back and DEB_CYCLES back, not just last cycle
  property p_trip_debounced;
    $rose(tripLvl) |-> $past(clean_q[SYN_TRIP_A] | clean_q[SYN_TRIP_B], 1)
      && $past(clean_q[SYN_TRIP_A] | clean_q[SYN_TRIP_B], DEB_CYCLES);
  endproperty
  a_trip_debounced: assert property (p_trip_debounced) else $error("trip level not debounced");
  property p_mask_outside_sleep;
    tripLvl && protActive && !inSleep && !clean_q[SYN_TEST] |-> !tripMaskEff;
  endproperty
  a_mask_outside_sleep: assert property (p_mask_outside_sleep) else $error("mask honoured awake");
  property p_shdn_sticky;
    shdnSts_q && !(wrLow && paddr == ADDR_SHDN_STS) |=> shdnSts_q;
  endproperty
  a_shdn_sticky: assert property (p_shdn_sticky) else $error("shutdown record lost");
  property p_irq_level;
    |(intSts_q & intMask_q) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  c_warning: cover property (warnRise ##[1:20] irq);
  c_trip: cover property (tripAct ##1 switchOffReq);
  c_restart_after_cool: cover property ($fell(restartBlocked_q) ##[1:50] restartGrant);
  c_masked_sleep: cover property (tripLvl && inSleep && tripMaskEff);

endmodule : die_thermal_monitor

//--- tb/power_sequencer_model.sv
// sequencer model: far side of the monitor's switch-off and restart levels
// assumes the monitor and this model share one clock and reset
module power_sequencer_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire thermal_monitor_pkg::powerState_t wantState,
  input wire logic wantRestart,
  input wire logic switchOffReq,
  input wire logic restartGrant,
  output thermal_monitor_pkg::powerState_t powerState,
  output logic restartReq
);
  timeunit 1ns;
  timeprecision 100ps;
  import thermal_monitor_pkg::*;

  // ----------------------------------------------------------------
  // switch-off latch
  // ----------------------------------------------------------------
  logic off_q;

  // stays off until granted: a hot die must never wake itself up
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      off_q <= 1'b0;
    end else if (switchOffReq) begin
      off_q <= 1'b1;
    end else if (restartGrant) begin
      off_q <= 1'b0;
    end
  end

  // state seen by the monitor; restart asked for only while off
  always_comb begin
    powerState = off_q ? PS_OFF : wantState;
    restartReq = off_q & wantRestart;
  end
endmodule : power_sequencer_model

//--- tb/test_die_thermal_monitor.sv
// self-checking bench for the die thermal monitor over apb
// assumes the sequencer model on the far side and a 200 MHz clock
module test_die_thermal_monitor;
  timeunit 1ns;
  timeprecision 100ps;
  import thermal_monitor_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic warnCmpA, warnCmpB, tripCmpA, tripCmpB, testMode, restartReq;
  logic switchOffReq, restartGrant, irq, wantRestart;
  logic [1:0] thrSel;
  powerState_t powerState, wantState;
  int errTotal, numChecks;

  die_thermal_monitor i_die_thermal_monitor (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .warnCmpA(warnCmpA),
    .warnCmpB(warnCmpB), .tripCmpA(tripCmpA), .tripCmpB(tripCmpB), .testMode(testMode),
    .powerState(powerState), .restartReq(restartReq), .thrSel(thrSel),
    .switchOffReq(switchOffReq), .restartGrant(restartGrant), .irq(irq));
  power_sequencer_model i_power_sequencer_model (.clock(clock), .rst_n(rst_n),
    .wantState(wantState), .wantRestart(wantRestart), .switchOffReq(switchOffReq),
    .restartGrant(restartGrant), .powerState(powerState), .restartReq(restartReq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      errTotal++;
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                         output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung access
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apbXfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apbXfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apbXfer(1'b0, a, 32'h0000_0000, r, e);
    check(what, exp, r);
  endtask : rdChk

  // bounded wait on an output: 0 irq, 1 switch-off, 2 grant
  task automatic waitHigh(input int k, input int lim);
    int n;
    n = 0;
    while ((k == 0 ? irq : k == 1 ? switchOffReq : restartGrant) !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask : waitHigh

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tReset;
    logic [31:0] r;
    logic e;
    check("thrSel", 32'h0, thrSel);
    check("switchOffReq", 32'h0, switchOffReq);
    rdChk("ctrl", ADDR_CTRL, 32'h0000_0001);
    rdChk("live", ADDR_LIVE, 32'h0000_0008);
    rdChk("shdn", ADDR_SHDN_STS, 32'h0000_0000);
    apbXfer(1'b0, 12'h020, 32'h0, r, e);
    check("pslverr", 32'h1, e);
  endtask : tReset

  task automatic tThreshold;
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_CTRL, 32'(t * 2 + 1));
      check("thrSel", 32'(t), thrSel);
      rdChk("ctrl", ADDR_CTRL, 32'(t * 2 + 1));
    end
  endtask : tThreshold

  // glitch, one excursion, held level, masked second excursion
  task automatic tWarning;
    wr(ADDR_INT_MASK, 32'h0000_0020);
    warnCmpA <= 1'b1;
    repeat (12) @(posedge clock);
    warnCmpA <= 1'b0;
    repeat (40) @(posedge clock);
    check("irq glitch", 32'h0, irq);
    warnCmpB <= 1'b1;
    waitHigh(0, 60);
    check("irq", 32'h1, irq);
    rdChk("int sts", ADDR_INT_STS, 32'h0000_0020);
    repeat (60) @(posedge clock);
    check("irq held", 32'h0, irq);
    rdChk("int sts held", ADDR_INT_STS, 32'h0000_0000);
    warnCmpB <= 1'b0;
    wr(ADDR_INT_MASK, 32'h0000_0000);
    repeat (40) @(posedge clock);
    warnCmpA <= 1'b1;
    repeat (60) @(posedge clock);
    check("irq masked", 32'h0, irq);
    rdChk("int sts again", ADDR_INT_STS, 32'h0000_0020);
    warnCmpA <= 1'b0;
    repeat (40) @(posedge clock);
  endtask : tWarning

  // glitch, sleep mask, unmasked trip, blocked restart, sticky record
  task automatic tTrip;
    tripCmpA <= 1'b1;
    repeat (12) @(posedge clock);
    tripCmpA <= 1'b0;
    repeat (40) @(posedge clock);
    check("trip glitch", 32'h0, switchOffReq);
    wantState <= PS_SLEEP;
    wr(ADDR_SLEEP_CFG, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    rdChk("sleep live", ADDR_LIVE, 32'h0000_0008);
    tripCmpB <= 1'b1;
    warnCmpA <= 1'b1;
    repeat (60) @(posedge clock);
    check("masked trip", 32'h0, switchOffReq);
    wantState <= PS_ACTIVE;
    waitHigh(1, 5);
    check("switchOffReq", 32'h1, switchOffReq);
    wantRestart <= 1'b1;
    rdChk("shdn", ADDR_SHDN_STS, 32'h0000_0001);
    tripCmpB <= 1'b0;
    repeat (40) @(posedge clock);
    check("grant hot", 32'h0, restartGrant);
    warnCmpA <= 1'b0;
    waitHigh(2, 60);
    check("grant", 32'h1, restartGrant);
    wantRestart <= 1'b0;
    rdChk("shdn kept", ADDR_SHDN_STS, 32'h0000_0001);
    wr(ADDR_SHDN_STS, 32'h0000_0001);
    rdChk("shdn cleared", ADDR_SHDN_STS, 32'h0000_0000);
  endtask : tTrip

  // no warning events while in backup
  task automatic tBackup;
    wr(ADDR_SLEEP_CFG, 32'h0000_0000);
    wr(ADDR_INT_MASK, 32'h0000_0020);
    // trip event from the last scenario plus the warning seen while asleep
    rdChk("sts drain", ADDR_INT_STS, 32'h0000_0021);
    wantState <= PS_BACKUP;
    warnCmpB <= 1'b1;
    repeat (60) @(posedge clock);
    check("irq backup", 32'h0, irq);
    warnCmpB <= 1'b0;
    repeat (40) @(posedge clock);
    wantState <= PS_ACTIVE;
    rdChk("int sts backup", ADDR_INT_STS, 32'h0000_0000);
  endtask : tBackup

  // trip mask honoured awake only while test mode holds, then armed again
  task automatic tTestMode;
    testMode <= 1'b1;
    wr(ADDR_SLEEP_CFG, 32'h0000_0001);
    tripCmpA <= 1'b1;
    repeat (60) @(posedge clock);
    check("test mask", 32'h0, switchOffReq);
    testMode <= 1'b0;
    waitHigh(1, 20);
    check("test unmask", 32'h1, switchOffReq);
    tripCmpA <= 1'b0;
    wantRestart <= 1'b1;
    waitHigh(2, 60);
    check("grant cool", 32'h1, restartGrant);
    wantRestart <= 1'b0;
  endtask : tTestMode

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : printVerdict

  // free-running clock, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // watchdog sized well above the fewer than one thousand cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    printVerdict;
  end

  initial begin
    {rst_n, psel, penable, pwrite, warnCmpA, warnCmpB, tripCmpA, tripCmpB} = 8'h00;
    {testMode, wantRestart, paddr, pwdata} = 46'h0;
    wantState = PS_ACTIVE;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    tReset;
    tThreshold;
    tWarning;
    tTrip;
    tBackup;
    tTestMode;
    printVerdict;
  end
endmodule : test_die_thermal_monitor
